// File: core/osq_pkg.sv
// constants, register map and types of the operational state sequencer
package osq_pkg;

  // ==========================================================================
  // clock and timing
  localparam int CLK_PERIOD_NS    = 8;      // 125 MHz core clock
  localparam int CLK_FREQ_KHZ     = 125000;
  localparam int WAKEUP_TIME_MS   = 4;
  localparam int WAKEUP_CYCLES    = WAKEUP_TIME_MS * CLK_FREQ_KHZ;
  localparam int PLL_LOCK_TIME_NS = 5000;
  localparam int PLL_LOCK_CYCLES  =
    (PLL_LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RING_DIV_CYCLES  = 4;      // core cycles per ring tick
  localparam int TMR_W            = 20;

  // ==========================================================================
  // register byte offsets (haddr[7:0])
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] CMD_OFS    = 8'h04;
  localparam logic [7:0] DELAY_OFS  = 8'h08;
  localparam logic [7:0] SLEEP_OFS  = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // command register bit positions
  localparam int CMD_TX_BIT  = 0;
  localparam int CMD_RX_BIT  = 1;
  localparam int CMD_DLY_BIT = 2;

  // status register bit positions above the state field
  localparam int STAT_DLY_BIT = 8;
  localparam int STAT_PLL_BIT = 9;

  // ==========================================================================
  // types
  typedef struct packed {
    logic restore_en;
    logic auto_sleep_after_rx;
    logic auto_sleep_after_tx;
    logic crystal_source;
    logic auto_seq_en;
  } osq_ctrl_type;

  localparam osq_ctrl_type CTRL_RST = '{restore_en: 1'b1,
                                        auto_sleep_after_rx: 1'b0,
                                        auto_sleep_after_tx: 1'b0,
                                        crystal_source: 1'b0,
                                        auto_seq_en: 1'b1};
  localparam logic [31:0] DELAY_RST = 32'h0000_0000;
  localparam logic [31:0] SLEEP_RST = 32'h0000_0100;

  typedef enum logic [5:0] {
    ST_WAKEUP = 6'b000001,
    ST_INIT   = 6'b000010,
    ST_IDLE   = 6'b000100,
    ST_TX     = 6'b001000,
    ST_RX     = 6'b010000,
    ST_SLEEP  = 6'b100000
  } osq_state_type;

  // address match used by both the write and the read decode
  function automatic logic osq_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    osq_hit = (addr == ofs);
  endfunction : osq_hit

endpackage : osq_pkg

// File: core/osq_sequencer.sv
// operational state sequencer with its ahb-lite register slave
//
// How it works
// - wake-up turns on crystal oscillator and band-gap reference.
// - about 4 ms into wake-up: digital regulator on, reset released, init.
// - init runs logic from the crystal divided by two, 19.2 MHz.
// - init entered after wake-up may reload settings from always-on store.
// - init starts the pll; 5 us later switch clock and go idle.
// - crystal source plus sequencing off returns idle to init and holds it.
// - idle keeps pll running but gates it off most logic.
// - idle accepts serial traffic up to 20 MHz.
// - idle keeps analog transmit and receive powered down.
// - start command in idle enters transmit or receive.
// - delayed command waits in idle until its delay expires.
// - transmit done returns idle, or sleeps if auto sleep and no irq.
// - receive end returns idle, or sleeps if auto sleep and no irq.
// - sleep counter on ring tick expires into wake-up.
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module osq_sequencer #(
  parameter int WAKEUP_CYCLES_P = osq_pkg::WAKEUP_CYCLES
) (
  // clock and reset
  input  wire  logic                  CORE_CLK_I,
  input  wire  logic                  SRST_I,
  // ahb-lite slave
  input  wire  logic                  HSEL_I,
  input  wire  logic [31:0]           HADDR_I,
  input  wire  logic [1:0]            HTRANS_I,
  input  wire  logic                  HWRITE_I,
  input  wire  logic [2:0]            HSIZE_I,
  input  wire  logic [31:0]           HWDATA_I,
  input  wire  logic                  HREADY_I,
  output logic       [31:0]           HRDATA_O,
  output logic                        HREADYOUT_O,
  output logic                        HRESP_O,
  // radio datapath events, same clock
  input  wire  logic                  TX_DONE_I,
  input  wire  logic                  RX_END_I,
  input  wire  logic                  IRQ_PENDING_I,
  // external wake pin, asynchronous
  input  wire  logic                  WAKE_PIN_I,
  // power and clock controls
  output logic                        CRYSTAL_SOURCE_EN_O,
  output logic                        BANDGAP_EN_O,
  output logic                        DIG_LDO_EN_O,
  output logic                        RESET_OUT_N_O,
  output logic                        PLL_EN_O,
  output logic                        CLK_SEL_PLL_O,
  output logic                        LOGIC_CLK_EN_O,
  output logic                        SPI_FAST_OK_O,
  output logic                        ANALOG_TX_EN_O,
  output logic                        ANALOG_RX_EN_O,
  output logic                        RESTORE_O,
  output osq_pkg::osq_state_type      STATE_O
);
  import osq_pkg::*;

  osq_state_type      state_ff;
  osq_state_type      nxt_state;
  osq_ctrl_type       ctrl_ff;
  logic [31:0]        delay_reg_ff;
  logic [31:0]        sleep_reg_ff;
  logic [TMR_W-1:0]   tmr_ff;
  logic               pll_locked_ff;
  logic               dly_pend_ff;
  logic               dly_rx_ff;
  logic [31:0]        dly_cnt_ff;
  logic [31:0]        sleep_cnt_ff;
  logic [2:0]         ring_div_ff;
  logic               ring_tick;
  logic               wsync1_ff;
  logic               wsync2_ff;
  logic               wsync3_ff;
  logic               wake_lvl_ff;
  logic               wake_rise;
  logic               wr_pend_ff;
  logic [7:0]         wr_addr_ff;
  logic               addr_phase;
  logic               wr_cmd;
  logic               cmd_tx;
  logic               cmd_rx;
  logic               cmd_dly;
  logic               wake_done;
  logic               pll_done;
  logic               dly_fire;
  logic               sleep_done;
  logic               restore_ff;

  // ==========================================================================
  // ahb-lite slave: zero wait states, always okay
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign addr_phase  = HSEL_I && HTRANS_I[1] && HREADY_I;

  // write address is held over to the data phase, where hwdata stands
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= addr_phase && HWRITE_I;
      wr_addr_ff <= HADDR_I[7:0];
    end
  end

  // software-written configuration
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      ctrl_ff      <= CTRL_RST;
      delay_reg_ff <= DELAY_RST;
      sleep_reg_ff <= SLEEP_RST;
    end else if (wr_pend_ff) begin
      if (osq_hit(wr_addr_ff, CTRL_OFS)) begin
        ctrl_ff <= osq_ctrl_type'(HWDATA_I[4:0]);
      end
      if (osq_hit(wr_addr_ff, DELAY_OFS)) begin
        delay_reg_ff <= HWDATA_I;
      end
      if (osq_hit(wr_addr_ff, SLEEP_OFS)) begin
        sleep_reg_ff <= HWDATA_I;
      end
    end
  end

  // read data is chosen in the address phase so it stands in the data phase
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      HRDATA_O <= 32'h0000_0000;
    end else if (addr_phase && !HWRITE_I) begin
      HRDATA_O <= 32'h0000_0000;  // unmapped and command read as zero
      if (osq_hit(HADDR_I[7:0], CTRL_OFS)) begin
        HRDATA_O[4:0] <= ctrl_ff;
      end
      if (osq_hit(HADDR_I[7:0], DELAY_OFS)) begin
        HRDATA_O <= delay_reg_ff;
      end
      if (osq_hit(HADDR_I[7:0], SLEEP_OFS)) begin
        HRDATA_O <= sleep_reg_ff;
      end
      if (osq_hit(HADDR_I[7:0], STATUS_OFS)) begin
        HRDATA_O[5:0]        <= state_ff;
        HRDATA_O[STAT_DLY_BIT] <= dly_pend_ff;
        HRDATA_O[STAT_PLL_BIT] <= pll_locked_ff;
      end
    end
  end

  // commands count only in idle with no delayed start already waiting
  assign wr_cmd  = wr_pend_ff && osq_hit(wr_addr_ff, CMD_OFS)
                   && (state_ff == ST_IDLE) && !dly_pend_ff;
  assign cmd_tx  = wr_cmd && HWDATA_I[CMD_TX_BIT];
  assign cmd_rx  = wr_cmd && HWDATA_I[CMD_RX_BIT] && !HWDATA_I[CMD_TX_BIT];
  assign cmd_dly = HWDATA_I[CMD_DLY_BIT];

  // ==========================================================================
  // wake pin synchroniser, a change counts once stages two and three agree
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      wsync1_ff   <= 1'b0;
      wsync2_ff   <= 1'b0;
      wsync3_ff   <= 1'b0;
      wake_lvl_ff <= 1'b0;
    end else begin
      wsync1_ff <= WAKE_PIN_I;
      wsync2_ff <= wsync1_ff;
      wsync3_ff <= wsync2_ff;
      if (wsync2_ff == wsync3_ff) begin
        wake_lvl_ff <= wsync3_ff;
      end
    end
  end
  assign wake_rise = wsync2_ff && wsync3_ff && !wake_lvl_ff;

  // ==========================================================================
  // time in state; cleared on every state change
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I || (nxt_state != state_ff)) begin
      tmr_ff <= '0;
    end else if (tmr_ff != {TMR_W{1'b1}}) begin
      tmr_ff <= tmr_ff + TMR_W'(1);
    end
  end
  assign wake_done = (state_ff == ST_WAKEUP)
                     && (tmr_ff == TMR_W'(WAKEUP_CYCLES_P - 1));
  assign pll_done  = (tmr_ff == TMR_W'(PLL_LOCK_CYCLES - 1));

  // pll lock is modelled by its lock time; it drops in wake-up and sleep
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      pll_locked_ff <= 1'b0;
    end else if (state_ff == ST_WAKEUP || state_ff == ST_SLEEP) begin
      pll_locked_ff <= 1'b0;
    end else if (state_ff == ST_INIT && pll_done) begin
      pll_locked_ff <= 1'b1;
    end
  end

  // delayed start: counts down in idle, fires at zero
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      dly_pend_ff <= 1'b0;
      dly_rx_ff   <= 1'b0;
      dly_cnt_ff  <= 32'h0000_0000;
    end else if ((cmd_tx || cmd_rx) && cmd_dly) begin
      dly_pend_ff <= 1'b1;
      dly_rx_ff   <= cmd_rx;
      dly_cnt_ff  <= delay_reg_ff;
    end else if (dly_fire) begin
      dly_pend_ff <= 1'b0;
    end else if (dly_pend_ff) begin
      dly_cnt_ff <= dly_cnt_ff - 32'h0000_0001;
    end
  end
  assign dly_fire = dly_pend_ff && (dly_cnt_ff == 32'h0000_0000);

  // ring oscillator stand-in: divided enable, only alive in sleep
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I || state_ff != ST_SLEEP) begin
      ring_div_ff <= 3'h0;
    end else if (ring_tick) begin
      ring_div_ff <= 3'h0;
    end else begin
      ring_div_ff <= ring_div_ff + 3'h1;
    end
  end
  assign ring_tick = (ring_div_ff == 3'(RING_DIV_CYCLES - 1));

  // sleep counter reloads on entry and counts ring ticks down
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      sleep_cnt_ff <= 32'h0000_0000;
    end else if (state_ff != ST_SLEEP) begin
      sleep_cnt_ff <= sleep_reg_ff;
    end else if (ring_tick && sleep_cnt_ff != 32'h0000_0000) begin
      sleep_cnt_ff <= sleep_cnt_ff - 32'h0000_0001;
    end
  end
  assign sleep_done = (sleep_cnt_ff == 32'h0000_0000);

  // ==========================================================================
  // next state; a pending host irq keeps the device awake after a frame
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_WAKEUP: begin
        if (wake_done) nxt_state = ST_INIT;
      end
      ST_INIT: begin
        if (pll_locked_ff && ctrl_ff.auto_seq_en && !ctrl_ff.crystal_source)
          nxt_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (ctrl_ff.crystal_source && !ctrl_ff.auto_seq_en)
          nxt_state = ST_INIT;
        else if (cmd_tx && !cmd_dly) nxt_state = ST_TX;
        else if (cmd_rx && !cmd_dly) nxt_state = ST_RX;
        else if (dly_fire) nxt_state = dly_rx_ff ? ST_RX : ST_TX;
      end
      ST_TX: begin
        if (TX_DONE_I)
          nxt_state = (ctrl_ff.auto_sleep_after_tx && !IRQ_PENDING_I)
                      ? ST_SLEEP : ST_IDLE;
      end
      ST_RX: begin
        if (RX_END_I)
          nxt_state = (ctrl_ff.auto_sleep_after_rx && !IRQ_PENDING_I)
                      ? ST_SLEEP : ST_IDLE;
      end
      ST_SLEEP: begin
        if ((ring_tick && sleep_done) || wake_rise)
          nxt_state = ST_WAKEUP;
      end
      default: nxt_state = ST_WAKEUP;
    endcase
  end

  // state register; reset lands in wake-up
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      state_ff <= ST_WAKEUP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // restore strobe on the first init cycle after wake-up
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      restore_ff <= 1'b0;
    end else begin
      restore_ff <= (state_ff == ST_WAKEUP) && (nxt_state == ST_INIT)
                    && ctrl_ff.restore_en;
    end
  end
  assign RESTORE_O = restore_ff;

  // power and clock outputs follow the next state so they align with state
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      CRYSTAL_SOURCE_EN_O      <= 1'b1;
      BANDGAP_EN_O   <= 1'b1;
      DIG_LDO_EN_O   <= 1'b0;
      RESET_OUT_N_O  <= 1'b0;
      PLL_EN_O       <= 1'b0;
      CLK_SEL_PLL_O  <= 1'b0;
      LOGIC_CLK_EN_O <= 1'b0;
      SPI_FAST_OK_O  <= 1'b0;
      ANALOG_TX_EN_O <= 1'b0;
      ANALOG_RX_EN_O <= 1'b0;
      STATE_O        <= ST_WAKEUP;
    end else begin
      CRYSTAL_SOURCE_EN_O      <= (nxt_state != ST_SLEEP);
      BANDGAP_EN_O   <= (nxt_state != ST_SLEEP);
      DIG_LDO_EN_O   <= !(nxt_state inside {ST_WAKEUP, ST_SLEEP});
      RESET_OUT_N_O  <= !(nxt_state inside {ST_WAKEUP, ST_SLEEP});
      PLL_EN_O       <= (nxt_state inside {ST_INIT, ST_IDLE, ST_TX, ST_RX});
      // halved crystal clock in init, pll afterwards
      CLK_SEL_PLL_O  <= (nxt_state inside {ST_IDLE, ST_TX, ST_RX});
      // idle gates the pll off most logic to save power
      LOGIC_CLK_EN_O <= (nxt_state inside {ST_INIT, ST_TX, ST_RX});
      SPI_FAST_OK_O  <= (nxt_state inside {ST_IDLE, ST_TX, ST_RX});
      ANALOG_TX_EN_O <= (nxt_state == ST_TX);
      ANALOG_RX_EN_O <= (nxt_state == ST_RX);
      STATE_O        <= nxt_state;
    end
  end

  // ==========================================================================
  // assertions
  property p_reset_wakeup;
    @(posedge CORE_CLK_I) $fell(SRST_I) |-> state_ff == ST_WAKEUP;
  endproperty
  a_reset_wakeup: assert property (p_reset_wakeup)
    else $error("reset did not land in wake-up");

  property p_wakeup_refs;
    @(posedge CORE_CLK_I) disable iff (SRST_I)
      state_ff == ST_WAKEUP |-> CRYSTAL_SOURCE_EN_O && BANDGAP_EN_O && !RESET_OUT_N_O;
  endproperty
  a_wakeup_refs: assert property (p_wakeup_refs)
    else $error("wake-up outputs wrong");

  property p_wakeup_exit;
    @(posedge CORE_CLK_I) disable iff (SRST_I)
      wake_done |=> state_ff == ST_INIT && RESET_OUT_N_O && DIG_LDO_EN_O;
  endproperty
  a_wakeup_exit: assert property (p_wakeup_exit)
    else $error("wake-up did not release reset into init");

  property p_init_clock;
    @(posedge CORE_CLK_I) disable iff (SRST_I)
      state_ff == ST_INIT |-> !CLK_SEL_PLL_O && LOGIC_CLK_EN_O;
  endproperty
  a_init_clock: assert property (p_init_clock)
    else $error("init not on halved crystal clock");

  property p_restore;
    @(posedge CORE_CLK_I) disable iff (SRST_I)
      $past(state_ff) == ST_WAKEUP && state_ff == ST_INIT
        |-> RESTORE_O == $past(ctrl_ff.restore_en);
  endproperty
  a_restore: assert property (p_restore)
    else $error("restore strobe wrong on init entry");

  property p_pll_to_idle;
    @(posedge CORE_CLK_I) disable iff (SRST_I)
      state_ff == ST_INIT && pll_locked_ff && ctrl_ff.auto_seq_en
        && !ctrl_ff.crystal_source |=> state_ff == ST_IDLE && CLK_SEL_PLL_O;
  endproperty
  a_pll_to_idle: assert property (p_pll_to_idle)
    else $error("locked init did not move to idle");

  property p_hold_init;
    @(posedge CORE_CLK_I) disable iff (SRST_I)
      state_ff inside {ST_INIT, ST_IDLE} && ctrl_ff.crystal_source
        && !ctrl_ff.auto_seq_en |=> state_ff == ST_INIT;
  endproperty
  a_hold_init: assert property (p_hold_init)
    else $error("crystal source without sequencing left init");

  property p_idle_outputs;
    @(posedge CORE_CLK_I) disable iff (SRST_I)
      state_ff == ST_IDLE |-> PLL_EN_O && !LOGIC_CLK_EN_O && SPI_FAST_OK_O
        && !ANALOG_TX_EN_O && !ANALOG_RX_EN_O;
  endproperty
  a_idle_outputs: assert property (p_idle_outputs)
    else $error("idle outputs wrong");

  property p_start_tx;
    @(posedge CORE_CLK_I) disable iff (SRST_I)
      cmd_tx && !cmd_dly && !(ctrl_ff.crystal_source && !ctrl_ff.auto_seq_en)
        |=> state_ff == ST_TX && ANALOG_TX_EN_O;
  endproperty
  a_start_tx: assert property (p_start_tx)
    else $error("immediate transmit not entered");

  property p_delay_wait;
    @(posedge CORE_CLK_I) disable iff (SRST_I)
      state_ff == ST_IDLE && dly_pend_ff && dly_cnt_ff > 32'h0000_0001
        && !(ctrl_ff.crystal_source && !ctrl_ff.auto_seq_en)
        |=> state_ff == ST_IDLE [*2];
  endproperty
  a_delay_wait: assert property (p_delay_wait)
    else $error("left idle before delay expired");

  property p_tx_end;
    @(posedge CORE_CLK_I) disable iff (SRST_I)
      state_ff == ST_TX && TX_DONE_I
        |=> state_ff == ($past(ctrl_ff.auto_sleep_after_tx && !IRQ_PENDING_I)
                         ? ST_SLEEP : ST_IDLE);
  endproperty
  a_tx_end: assert property (p_tx_end)
    else $error("wrong state after transmit");

  property p_rx_end;
    @(posedge CORE_CLK_I) disable iff (SRST_I)
      state_ff == ST_RX && RX_END_I
        |=> state_ff == ($past(ctrl_ff.auto_sleep_after_rx && !IRQ_PENDING_I)
                         ? ST_SLEEP : ST_IDLE);
  endproperty
  a_rx_end: assert property (p_rx_end)
    else $error("wrong state after receive");

  property p_sleep_expire;
    @(posedge CORE_CLK_I) disable iff (SRST_I)
      state_ff == ST_SLEEP && ring_tick && sleep_done
        |=> state_ff == ST_WAKEUP && CRYSTAL_SOURCE_EN_O && !RESET_OUT_N_O;
  endproperty
  a_sleep_expire: assert property (p_sleep_expire)
    else $error("sleep expiry did not wake");

endmodule : osq_sequencer

// File: tb/osq_host_model.sv
// host microcontroller model: ahb-lite master for the sequencer registers
`timescale 1ns/1ps
module osq_host_model (
  // clock and bus answer
  input  wire logic        clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  // ahb-lite master outputs
  output logic             hsel_o,
  output logic [31:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [2:0]       hsize_o,
  output logic [31:0]      hwdata_o
);
  // ======
  // bus idle at time zero
  initial begin
    hsel_o   = 1'b0;
    haddr_o  = 32'h0;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hsize_o  = 3'b000;
    hwdata_o = 32'h0;
  end

  // ======
  // one word transfer, paced only by hready; callers keep off lock
  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    hsel_o   <= 1'b1;
    haddr_o  <= a;
    htrans_o <= 2'b10;
    hwrite_o <= wr;
    hsize_o  <= 3'b010;  // whole word only
    do @(posedge clk_i); while (hready_i !== 1'b1);
    htrans_o <= 2'b00;
    hwdata_o <= d;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    q = hrdata_i;
    hsel_o   <= 1'b0;
    // released address and data lines never keep the last value
    haddr_o  <= ~a;
    hwdata_o <= ~d;
    #1;
  endtask : xfer
endmodule : osq_host_model

// File: tb/tb_top.sv
// self-checking bench: state walk, commands, auto sleep, re-init
`timescale 1ns/1ps
module tb_top;
  import osq_pkg::*;
  // ======
  // stimulus and observed signals
  localparam int WK = 50;  // short wake-up count keeps the run brief
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          irq = 1'b0;
  logic          wake = 1'b0;
  logic [1:0]    ev = 2'b00;  // {rx end, tx done}
  int            seed = 39;
  int            cyc = 0;
  int            n_mismatch = 0;
  int            tests_run = 0;
  wire           hsel, hwrite, hready, hresp, restore;
  wire [1:0]     htrans;
  wire [2:0]     hsize;
  wire [31:0]    haddr, hwdata, hrdata;
  wire [9:0]     ctl;
  osq_state_type st;
  logic [7:0]    ofs [5] = '{CTRL_OFS, CMD_OFS, DELAY_OFS, SLEEP_OFS, 8'h14};
  logic [31:0]   rv [5] = '{{27'h0, CTRL_RST}, 32'h0, DELAY_RST,
                            SLEEP_RST, 32'h0};

  osq_host_model host (.clk_i(clk), .hready_i(hready), .hrdata_i(hrdata),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
    .hwdata_o(hwdata), .hsize_o(hsize));
  osq_sequencer #(.WAKEUP_CYCLES_P(WK)) uut (.CORE_CLK_I(clk),
    .SRST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .TX_DONE_I(ev[0]), .RX_END_I(ev[1]),
    .IRQ_PENDING_I(irq), .WAKE_PIN_I(wake), .CRYSTAL_SOURCE_EN_O(ctl[9]),
    .BANDGAP_EN_O(ctl[8]), .DIG_LDO_EN_O(ctl[7]),
    .RESET_OUT_N_O(ctl[6]), .PLL_EN_O(ctl[5]), .CLK_SEL_PLL_O(ctl[4]),
    .LOGIC_CLK_EN_O(ctl[3]), .SPI_FAST_OK_O(ctl[2]),
    .ANALOG_TX_EN_O(ctl[1]), .ANALOG_RX_EN_O(ctl[0]),
    .RESTORE_O(restore), .STATE_O(st));

  // ======
  // clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ======
  // reference model: control outputs decoded from the expected state
  function automatic logic [9:0] ctl_of(input osq_state_type s);
    logic w, i, d, t, r, z;
    w = (s == ST_WAKEUP);
    i = (s == ST_INIT);
    d = (s == ST_IDLE);
    t = (s == ST_TX);
    r = (s == ST_RX);
    z = (s == ST_SLEEP);
    return {~z, ~z, ~(w | z), ~(w | z), i | d | t | r, d | t | r,
            i | t | r, d | t | r, t, r};
  endfunction : ctl_of

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // bounded wait, then state and every control output compared
  task automatic wait_st(input osq_state_type s, input int lim);
    int n;
    n = 0;
    while (st !== s && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("state", st, s);
    check("ctl", ctl, ctl_of(s));
  endtask : wait_st

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, {24'h0, a}, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b0, {24'h0, a}, 32'h0, q);
    check("rdata", q, e);
    check("hresp", hresp, 32'h0);
    check("hready", hready, 32'h1);
  endtask : rd

  // wake-up to idle, timed against the shortened wake-up count WK and the documented pll lock wait
  task automatic bring_up(input int t0);
    wait_st(ST_INIT, WK + 40);
    check("wake_len", (cyc - t0) inside {[WK - 2:WK + 2]}, 1);
    check("restore", restore, 1);
    t0 = cyc;
    wait_st(ST_IDLE, 700);
    check("lock_len", (cyc - t0) inside {[622:630]}, 1);
    rd(STATUS_OFS, 32'h204);
  endtask : bring_up

  // k bit0 picks rx, bit1 picks a delayed start of random length;
  // the rx bit is always set, so a tx start also shows that tx wins
  task automatic run(input int k, input osq_state_type fin);
    int dly;
    int t;
    dly = 4 + ($random(seed) & 7);
    if (k[1]) wr(DELAY_OFS, 32'(dly));
    wr(CMD_OFS, {29'h0, k[1], 1'b1, ~k[0]});
    t = cyc;
    if (k[1]) rd(STATUS_OFS, 32'h304);
    wait_st(k[0] ? ST_RX : ST_TX, 20);
    check("start_lat", k[1] ? ((cyc - t) inside {[dly + 1:dly + 3]})
                            : (cyc - t == 0), 1);
    @(posedge clk) ev <= k[0] ? 2'b10 : 2'b01;
    @(posedge clk) ev <= 2'b00;
    #1;
    wait_st(fin, 4);
  endtask : run

  // ======
  // main sequence
  initial begin
    int t0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t0 = cyc;
    wait_st(ST_WAKEUP, 1);
    foreach (ofs[j]) rd(ofs[j], rv[j]);
    bring_up(t0);
    for (int k = 0; k < 4; k++) run(k, ST_IDLE);
    // auto sleep, first held off by a pending interrupt
    wr(CTRL_OFS, 32'h1d);
    wr(SLEEP_OFS, 32'h2);
    @(posedge clk) irq <= 1'b1;
    run(0, ST_IDLE);
    @(posedge clk) irq <= 1'b0;
    run(1, ST_SLEEP);
    t0 = cyc;
    wait_st(ST_WAKEUP, 30);
    check("sleep_len", (cyc - t0) inside {[9:16]}, 1);
    bring_up(cyc);
    // long sleep cut short by the wake pin
    wr(SLEEP_OFS, 32'hff);
    run(2, ST_SLEEP);
    @(posedge clk) wake <= 1'b1;
    wait_st(ST_WAKEUP, 8);
    @(posedge clk) wake <= 1'b0;
    bring_up(cyc);
    // crystal source with sequencing off holds init; commands ignored
    wr(CTRL_OFS, 32'h12);
    wait_st(ST_INIT, 4);
    wr(CMD_OFS, 32'h1);
    repeat (700) @(posedge clk);
    #1;
    wait_st(ST_INIT, 0);
    wr(CTRL_OFS, 32'h11);
    wait_st(ST_IDLE, 700);
    // reset in mid-run lands in wake-up with the sleep register back at reset
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t0 = cyc;
    wait_st(ST_WAKEUP, 0);
    rd(SLEEP_OFS, SLEEP_RST);
    bring_up(t0);
    report_and_stop();
  end
endmodule : tb_top
